// ==== src/pmc_map.svh ====
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// Register byte offsets (Avalon-MM, one 32-bit word each)
`define PMC_OFS_MISC 4'h0
`define PMC_OFS_CLKCTRL 4'h4
`define PMC_OFS_OPTION 4'h8
`define PMC_OFS_STATUS 4'hc

// Field positions
`define PMC_MISC_SLOW_BIT 0
`define PMC_MISC_SEL_LSB 1
`define PMC_MISC_SEL_MSB 2
`define PMC_CLKCTRL_TBIE_BIT 0
`define PMC_OPTION_WATCHDOG_HALT_OPTION_BIT 0
`define PMC_STATUS_MODE_LSB 0
`define PMC_STATUS_MODE_MSB 2
`define PMC_STATUS_HOLD_BIT 3
`define PMC_STATUS_DIV_LSB 4
`define PMC_STATUS_DIV_MSB 9

// Reset values
`define PMC_RST_SLOW 1'h0
`define PMC_RST_SEL 2'h0
`define PMC_RST_TBIE 1'h0
`define PMC_RST_WATCHDOG_HALT_OPTION 1'h0

// Master clock divisors of the oscillator
`define PMC_DIV_RUN 6'h02
`define PMC_DIV_SLOW_BASE 6'h04

// Start-up delay after halt modes, in CPU cycles
`define PMC_STARTUP_CPU_CYCLES 4096

`endif

// ==== src/pmc_pkg.sv ====
package pmc_pkg;

   typedef enum logic [2:0] {
      PMC_RUN = 3'h0,
      PMC_WAIT = 3'h1,
      PMC_AHALT = 3'h3,
      PMC_HALT = 3'h2,
      PMC_STARTUP = 3'h6
   } pmc_mode_t;

   typedef struct packed {
      logic slowEnable;
      logic [1:0] clockPrescaleSel;
   } pmc_clk_cfg_t;

   typedef struct packed {
      logic [5:0] cnt;
      logic [5:0] div;
      logic tick;
   } pmc_div_state_t;

   typedef struct packed {
      logic cpuClkEn;
      logic periphClkEn;
      logic timebaseClkEn;
      logic oscEnable;
   } pmc_gates_t;

   typedef struct packed {
      pmc_mode_t mode;
      pmc_clk_cfg_t cfg;
      logic timebaseIrqEnable;
      logic watchdogHaltOption;
      logic [12:0] startCnt;
      logic [3:0] extSync1;
      logic [3:0] extSync2;
      logic ack;
      logic [31:0] rdData;
      logic iMaskClr;
      logic iMaskSet;
      logic wakeGo;
      logic wdgResetReq;
   } pmc_state_t;

endpackage : pmc_pkg

// ==== src/pmc_clk_div.sv ====
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_clk_div (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic oscRun,
   input wire pmc_pkg::pmc_clk_cfg_t cfg,
   output logic tick,
   output logic [5:0] divNow
);

   pmc_pkg::pmc_div_state_t s_q;
   pmc_pkg::pmc_div_state_t s_d;

   function automatic logic [5:0] divOf(input pmc_pkg::pmc_clk_cfg_t c);
      divOf = c.slowEnable ? 6'(`PMC_DIV_SLOW_BASE << c.clockPrescaleSel) : `PMC_DIV_RUN;
   endfunction : divOf

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!oscRun) begin
         // Oscillator off: no master-clock edges at all
         s_d.cnt = 6'h00;
      end else if (s_q.cnt == 6'(s_q.div - 6'h01)) begin
         s_d.cnt = 6'h00;
         s_d.tick = 1'b1;
         s_d.div = divOf(cfg);
      end else begin
         s_d.cnt = 6'(s_q.cnt + 6'h01);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{cnt: 6'h00, div: `PMC_DIV_RUN, tick: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
   assign divNow = s_q.div;

endmodule : pmc_clk_div

// ==== src/pmc_power_mode_controller.sv ====
// How it works
// - After reset run mode, master clock is oscillator divided by two.
// - Slow operation set by slow_enable and two-bit clock_prescale_sel.
// - Slow mode divides the oscillator by 4, 8, 16 or 32.
// - In slow mode CPU and peripherals both get the reduced clock.
// - Wait while slow gives slow-wait: peripherals slow, CPU stopped.
// - Wait instruction stops the CPU clock, peripherals keep running.
// - Entering wait clears the interrupt mask bit, nothing else.
// - Wait lasts until interrupt or reset, then the service routine starts.
// - Halt gives plain halt if timebase_irq_enable is 0, active-halt if 1.
// - Active-halt ends on timebase, designated wake interrupt or reset.
// - Wake from active-halt waits 4096 CPU cycles before resuming.
// - Entering active-halt clears the interrupt mask bit.
// - In active-halt only oscillator and timebase counter are clocked.
// - With timebase_irq_enable set, active-halt never causes a watchdog reset.
// - Wake from plain halt restarts oscillator, holds CPU 4096 cycles.
// - Entering plain halt forces the interrupt mask bit to zero.
// - Plain halt switches the oscillator off, stopping all peripherals.
// - watchdog_halt_option decides if halt with watchdog gives watchdog reset.
// - Servicing a wake interrupt sets the mask bit; popping clears it.
// - Any interrupt ends wait; only external or designated ones end halt.
// - Timebase and clock-security interrupts end active-halt, not plain halt.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_power_mode_controller #(
   parameter int STARTUP_CYCLES = `PMC_STARTUP_CPU_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU core
   input wire logic waitForInterruptInstr,
   input wire logic haltInstr,
   input wire logic irqServiceStart,
   input wire logic ccPop,
   // Interrupt sources
   input wire logic irqPeriph,
   input wire logic irqWakeCapable,
   input wire logic timebaseIrq,
   input wire logic clockSecurityIrq,
   input wire logic [3:0] extIrqPin,
   input wire logic watchdogActive,
   // Clock control
   output logic masterTick,
   output logic cpuClkEn,
   output logic periphClkEn,
   output logic timebaseClkEn,
   output logic oscEnable,
   output logic cpuHold,
   output logic iMaskClr,
   output logic iMaskSet,
   output logic wakeGo,
   output logic wdgResetReq
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam logic [12:0] START_LAST = 13'(STARTUP_CYCLES - 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pmc_pkg::pmc_state_t s_q;
   pmc_pkg::pmc_state_t s_d;
   pmc_pkg::pmc_gates_t gates;
   logic [5:0] divNow;
   logic tick;
   logic anyIrq;
   logic haltWake;
   logic activeHaltWake;
   logic busReq;
   logic busDone;
   logic [31:0] wrMasked;

   // ----------------------------------------------------------------
   // Master clock divider
   // ----------------------------------------------------------------
   pmc_clk_div u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .oscRun(gates.oscEnable),
      .cfg(s_q.cfg),
      .tick(tick),
      .divNow(divNow)
   );

   // ----------------------------------------------------------------
   // Clock gating per mode
   // ----------------------------------------------------------------
   // Enables decode the registered mode only, so bus or interrupt activity never glitches them
   always_comb begin
      gates = '{cpuClkEn: 1'b0, periphClkEn: 1'b0, timebaseClkEn: 1'b0, oscEnable: 1'b1};
      case (s_q.mode)
         pmc_pkg::PMC_RUN: begin
            gates.cpuClkEn = 1'b1;
            gates.periphClkEn = 1'b1;
            gates.timebaseClkEn = 1'b1;
         end
         pmc_pkg::PMC_WAIT: begin
            gates.periphClkEn = 1'b1;
            gates.timebaseClkEn = 1'b1;
         end
         pmc_pkg::PMC_AHALT: begin
            gates.timebaseClkEn = 1'b1;
         end
         pmc_pkg::PMC_HALT: begin
            gates.oscEnable = 1'b0;
         end
         pmc_pkg::PMC_STARTUP: begin
            gates.timebaseClkEn = 1'b1;
         end
         default: begin
            gates.cpuClkEn = 1'b1;
            gates.periphClkEn = 1'b1;
            gates.timebaseClkEn = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Wake sources
   // ----------------------------------------------------------------
   // Levels, not edges: a request already pending at entry ends the mode
   // on the next edge, which is what the cleared mask bit relies on
   // Wait ends on any source
   assign anyIrq = irqPeriph | irqWakeCapable | timebaseIrq | clockSecurityIrq | (|s_q.extSync2);
   // Halt ends on external or designated only
   assign haltWake = irqWakeCapable | (|s_q.extSync2);
   // Timebase and clock security add to active-halt
   assign activeHaltWake = haltWake | timebaseIrq | clockSecurityIrq;

   // ----------------------------------------------------------------
   // Bus helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] beMask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : beMask

   assign busReq = avs_read | avs_write;
   // One wait cycle, then the access completes
   // Costs a cycle per access but keeps readdata straight from a flop,
   // with no address-to-data path through the decoder
   assign busDone = busReq & s_q.ack;
   assign wrMasked = avs_writedata & beMask(avs_byteenable);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.iMaskClr = 1'b0;
      s_d.iMaskSet = 1'b0;
      s_d.wakeGo = 1'b0;
      s_d.wdgResetReq = 1'b0;

      // External pins pass two flops first
      s_d.extSync1 = extIrqPin;
      s_d.extSync2 = s_q.extSync1;

      // Register bus
      s_d.ack = busReq & ~s_q.ack;
      if (busReq & ~s_q.ack) begin
         s_d.rdData = 32'h00000000;
         if (avs_address == `PMC_OFS_MISC) begin
            s_d.rdData[`PMC_MISC_SLOW_BIT] = s_q.cfg.slowEnable;
            s_d.rdData[`PMC_MISC_SEL_MSB:`PMC_MISC_SEL_LSB] = s_q.cfg.clockPrescaleSel;
         end else if (avs_address == `PMC_OFS_CLKCTRL) begin
            s_d.rdData[`PMC_CLKCTRL_TBIE_BIT] = s_q.timebaseIrqEnable;
         end else if (avs_address == `PMC_OFS_OPTION) begin
            s_d.rdData[`PMC_OPTION_WATCHDOG_HALT_OPTION_BIT] = s_q.watchdogHaltOption;
         end else if (avs_address == `PMC_OFS_STATUS) begin
            s_d.rdData[`PMC_STATUS_MODE_MSB:`PMC_STATUS_MODE_LSB] = s_q.mode;
            s_d.rdData[`PMC_STATUS_HOLD_BIT] = (s_q.mode == pmc_pkg::PMC_STARTUP);
            s_d.rdData[`PMC_STATUS_DIV_MSB:`PMC_STATUS_DIV_LSB] = divNow;
         end else begin
            // Unmapped offsets read zero
            s_d.rdData = 32'h00000000;
         end
      end
      if (busDone & avs_write) begin
         if (avs_address == `PMC_OFS_MISC) begin
            if (avs_byteenable[0]) begin
               s_d.cfg.slowEnable = wrMasked[`PMC_MISC_SLOW_BIT];
               s_d.cfg.clockPrescaleSel = wrMasked[`PMC_MISC_SEL_MSB:`PMC_MISC_SEL_LSB];
            end
         end else if (avs_address == `PMC_OFS_CLKCTRL) begin
            if (avs_byteenable[0]) begin
               s_d.timebaseIrqEnable = wrMasked[`PMC_CLKCTRL_TBIE_BIT];
            end
         end else if (avs_address == `PMC_OFS_OPTION) begin
            if (avs_byteenable[0]) begin
               s_d.watchdogHaltOption = wrMasked[`PMC_OPTION_WATCHDOG_HALT_OPTION_BIT];
            end
         end else begin
            // Status and unmapped offsets ignore writes
            s_d.rdData = s_q.rdData;
         end
      end

      // Mask set on service, cleared on pop
      if (irqServiceStart) begin
         s_d.iMaskSet = 1'b1;
      end
      if (ccPop) begin
         s_d.iMaskClr = 1'b1;
      end

      // Mode sequencer
      case (s_q.mode)
         pmc_pkg::PMC_RUN: begin
            if (waitForInterruptInstr) begin
               // Divider untouched, so slow-wait keeps reduced clock
               s_d.mode = pmc_pkg::PMC_WAIT;
               s_d.iMaskClr = 1'b1;
               s_d.iMaskSet = 1'b0;
            end else if (haltInstr) begin
               s_d.iMaskClr = 1'b1;
               s_d.iMaskSet = 1'b0;
               if (s_q.timebaseIrqEnable) begin
                  s_d.mode = pmc_pkg::PMC_AHALT;
               end else if (watchdogActive && s_q.watchdogHaltOption) begin
                  s_d.wdgResetReq = 1'b1;
               end else begin
                  // Mask forced to zero on entry
                  s_d.mode = pmc_pkg::PMC_HALT;
               end
            end
         end
         pmc_pkg::PMC_WAIT: begin
            // Stay until an interrupt, then service it
            if (anyIrq) begin
               s_d.mode = pmc_pkg::PMC_RUN;
               s_d.wakeGo = 1'b1;
            end
         end
         pmc_pkg::PMC_AHALT: begin
            if (activeHaltWake) begin
               s_d.mode = pmc_pkg::PMC_STARTUP;
               s_d.startCnt = 13'h0000;
            end
         end
         pmc_pkg::PMC_HALT: begin
            if (haltWake) begin
               s_d.mode = pmc_pkg::PMC_STARTUP;
               s_d.startCnt = 13'h0000;
            end
         end
         pmc_pkg::PMC_STARTUP: begin
            // Count restarted CPU cycles to terminal value
            // No ticks arrive while the oscillator is off, so halt time never counts
            if (tick) begin
               if (s_q.startCnt == START_LAST) begin
                  s_d.mode = pmc_pkg::PMC_RUN;
                  s_d.wakeGo = 1'b1;
               end else begin
                  s_d.startCnt = 13'(s_q.startCnt + 13'h0001);
               end
            end
         end
         default: begin
            s_d.mode = pmc_pkg::PMC_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset lands in run with divide-by-two
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{
            mode: pmc_pkg::PMC_RUN,
            cfg: '{slowEnable: `PMC_RST_SLOW, clockPrescaleSel: `PMC_RST_SEL},
            timebaseIrqEnable: `PMC_RST_TBIE,
            watchdogHaltOption: `PMC_RST_WATCHDOG_HALT_OPTION,
            startCnt: 13'h0000,
            extSync1: 4'h0,
            extSync2: 4'h0,
            ack: 1'b0,
            rdData: 32'h00000000,
            iMaskClr: 1'b0,
            iMaskSet: 1'b0,
            wakeGo: 1'b0,
            wdgResetReq: 1'b0
         };
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Master tick rate follows the selected divisor
   // No tick once oscillator off
   // The divider tick lags the mode by one edge, so without this gate the
   // halt entry edge could leak a last master-clock pulse into halt
   assign masterTick = tick & gates.oscEnable;
   assign cpuClkEn = gates.cpuClkEn;
   assign periphClkEn = gates.periphClkEn;
   assign timebaseClkEn = gates.timebaseClkEn;
   assign oscEnable = gates.oscEnable;
   assign cpuHold = (s_q.mode == pmc_pkg::PMC_STARTUP);
   assign iMaskClr = s_q.iMaskClr;
   assign iMaskSet = s_q.iMaskSet;
   assign wakeGo = s_q.wakeGo;
   assign wdgResetReq = s_q.wdgResetReq;
   assign avs_readdata = s_q.rdData;
   assign avs_waitrequest = busReq & ~s_q.ack;

endmodule : pmc_power_mode_controller

// ==== tb/pmc_power_mode_controller_sva.sv ====
`timescale 1ns/1ps
module pmc_power_mode_controller_sva #(
   parameter int STARTUP_CYCLES = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic waitForInterruptInstr,
   input wire logic haltInstr,
   input wire logic irqServiceStart,
   input wire logic ccPop,
   input wire logic irqPeriph,
   input wire logic irqWakeCapable,
   input wire logic timebaseIrq,
   input wire logic [3:0] extIrqPin,
   input wire logic masterTick,
   input wire logic cpuClkEn,
   input wire logic periphClkEn,
   input wire logic timebaseClkEn,
   input wire logic oscEnable,
   input wire logic cpuHold,
   input wire logic iMaskClr,
   input wire logic iMaskSet,
   input wire logic wakeGo,
   input wire logic wdgResetReq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Mode decode from the gate outputs
   // ----------------------------------------
   wire run = cpuClkEn && periphClkEn && oscEnable && !cpuHold;
   wire inWait = !cpuClkEn && periphClkEn && !cpuHold;
   wire inAhalt = oscEnable && timebaseClkEn && !periphClkEn && !cpuHold;
   wire inHalt = !oscEnable;
   wire entryNow = run && (waitForInterruptInstr || haltInstr);
   logic [15:0] tickCnt;
   // Edge of the last tick may land with the release, so one short is allowed
   wire cntOk = tickCnt >= 16'(STARTUP_CYCLES - 1) && tickCnt <= 16'(STARTUP_CYCLES);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         tickCnt <= '0;
      else if (!cpuHold)
         tickCnt <= '0;
      else if (masterTick)
         tickCnt <= tickCnt + 16'h1;
   end
   sequence s_waitEntry;
      run && waitForInterruptInstr;
   endsequence
   sequence s_haltEntry;
      run && haltInstr && !waitForInterruptInstr;
   endsequence
   property p_waitGate;
      s_waitEntry |=> inWait && iMaskClr;
   endproperty
   a_waitGate: assert property (p_waitGate) else $error("wait entry gating wrong");
   property p_haltGate;
      s_haltEntry |=> (inHalt && !timebaseClkEn || inAhalt && !cpuClkEn) && iMaskClr || wdgResetReq;
   endproperty
   a_haltGate: assert property (p_haltGate) else $error("halt entry gating wrong");
   property p_haltDark;
      inHalt |-> !masterTick && !cpuClkEn && !periphClkEn && !timebaseClkEn;
   endproperty
   a_haltDark: assert property (p_haltDark) else $error("clock alive in halt");
   property p_ahaltNoWdg;
      inAhalt |-> !wdgResetReq && !periphClkEn && !cpuClkEn;
   endproperty
   a_ahaltNoWdg: assert property (p_ahaltNoWdg) else $error("active halt leak");
   property p_haltStay;
      inHalt && !irqWakeCapable && extIrqPin == 4'h0 && $past(extIrqPin) == 4'h0 && $past(extIrqPin, 2) == 4'h0
         && $past(extIrqPin, 3) == 4'h0 |=> inHalt;
   endproperty
   a_haltStay: assert property (p_haltStay) else $error("halt left without wake source");
   property p_ahaltWake;
      inAhalt && timebaseIrq |=> cpuHold;
   endproperty
   a_ahaltWake: assert property (p_ahaltWake) else $error("timebase did not wake");
   property p_waitWake;
      inWait && irqPeriph |=> cpuClkEn && wakeGo;
   endproperty
   a_waitWake: assert property (p_waitWake) else $error("wait not left on irq");
   property p_startup;
      $fell(cpuHold) |-> cntOk ##[0:1] wakeGo;
   endproperty
   a_startup: assert property (p_startup) else $error("start-up length wrong");
   property p_svcMask;
      irqServiceStart && !entryNow && !ccPop |=> iMaskSet;
   endproperty
   a_svcMask: assert property (p_svcMask) else $error("mask not set");
   property p_popMask;
      ccPop |=> iMaskClr;
   endproperty
   a_popMask: assert property (p_popMask) else $error("mask not cleared");
endmodule : pmc_power_mode_controller_sva

bind pmc_power_mode_controller pmc_power_mode_controller_sva #(
   .STARTUP_CYCLES(STARTUP_CYCLES)
) u_sva (.*);

// ==== tb/pmc_cpu_model.sv ====
`timescale 1ns/1ps
module pmc_cpu_model #(
   parameter logic [3:0] POP_AT = 4'h6
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wakeGo,
   output logic waitForInterruptInstr,
   output logic haltInstr,
   output logic irqServiceStart,
   output logic ccPop
);
   logic [3:0] svc_q;
   initial begin
      waitForInterruptInstr = 1'b0;
      haltInstr = 1'b0;
   end
   task automatic exec(input logic isHalt);
      @(posedge mclk);
      waitForInterruptInstr <= !isHalt;
      haltInstr <= isHalt;
      @(posedge mclk);
      waitForInterruptInstr <= 1'b0;
      haltInstr <= 1'b0;
   endtask : exec
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         svc_q <= 4'h0;
      else if (wakeGo)
         svc_q <= 4'h1;
      else if (svc_q != 4'h0)
         svc_q <= (svc_q == POP_AT) ? 4'h0 : svc_q + 4'h1;
   end
   assign irqServiceStart = svc_q == 4'h1;
   assign ccPop = svc_q == POP_AT;
endmodule : pmc_cpu_model

// ==== tb/pmc_power_mode_controller_bench.sv ====
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_power_mode_controller_bench;
   localparam int SC = 8;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic waitForInterruptInstr, haltInstr, irqServiceStart, ccPop;
   logic irqPeriph = 1'b0;
   logic irqWakeCapable = 1'b0;
   logic timebaseIrq = 1'b0;
   logic clockSecurityIrq = 1'b0;
   logic [3:0] extIrqPin = 4'h0;
   logic watchdogActive = 1'b0;
   logic masterTick, cpuClkEn, periphClkEn, timebaseClkEn, oscEnable, cpuHold;
   logic iMaskClr, iMaskSet, wakeGo, wdgResetReq;
   logic wrqS, tickS, goS, wdgSeen;
   logic [31:0] rdS, rv;
   logic [1:0] sel;
   int per;
   int n_mismatch = 0;
   int total_checks = 0;
   always #4 mclk = ~mclk;
   pmc_power_mode_controller #(.STARTUP_CYCLES(SC)) dut (.*);
   pmc_cpu_model cpu (.*);
   // Sample between edges so no result hangs on process order
   always @(negedge mclk) begin
      wrqS = avs_waitrequest;
      rdS = avs_readdata;
      tickS = masterTick;
      goS = wakeGo;
      if (wdgResetReq === 1'b1)
         wdgSeen = 1'b1;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] expPeriod(input logic slow, input logic [1:0] ps);
      return slow ? (32'h4 << ps) : 32'h2;
   endfunction : expPeriod
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge mclk); while (wrqS !== 1'b0);
      rv = rdS;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic period(output int p);
      repeat (2) begin
         do @(posedge mclk); while (tickS !== 1'b1);
      end
      p = 0;
      do begin
         @(posedge mclk);
         p++;
      end while (tickS !== 1'b1);
   endtask : period
   task automatic at_neg(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : at_neg
   task automatic wait_go(input int lim);
      int k;
      k = 0;
      while (goS !== 1'b1 && k < lim) begin
         @(posedge mclk);
         k++;
      end
      check("wake", 32'(k < lim), 32'h1);
   endtask : wait_go
   task automatic gates(input string nm, input logic [3:0] exp);
      check(nm, 32'({cpuClkEn, periphClkEn, timebaseClkEn, oscEnable}), 32'(exp));
   endtask : gates
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      $display("BAD watchdog expected finish seen hang");
      print_verdict();
   end
   initial begin
      rv = $urandom(57);
      wdgSeen = 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      // ----------------------------------------
      // Reset state and register access
      // ----------------------------------------
      at_neg(0);
      gates("reset gates", 4'hf);
      bus(1'b1, `PMC_OFS_STATUS, 32'hffff_ffff);
      bus(1'b0, `PMC_OFS_STATUS, 32'h0);
      check("status", rv, {22'h0, `PMC_DIV_RUN, 4'h0});
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rv, 32'h0);
      avs_byteenable <= 4'h0;
      bus(1'b1, `PMC_OFS_MISC, 32'h7);
      avs_byteenable <= 4'hf;
      bus(1'b0, `PMC_OFS_MISC, 32'h0);
      check("misc", rv, 32'h0);
      period(per);
      check("run period", 32'(per), expPeriod(1'b0, 2'h0));
      $display("test reset finished");
      // ----------------------------------------
      // Slow divider, every prescale code
      // ----------------------------------------
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, `PMC_OFS_MISC, {29'h0, 2'(s), 1'b1});
         period(per);
         check("slow period", 32'(per), expPeriod(1'b1, 2'(s)));
         bus(1'b0, `PMC_OFS_STATUS, 32'h0);
         check("slow div", rv & 32'h3f0, expPeriod(1'b1, 2'(s)) << 4);
      end
      $display("test slow finished");
      // ----------------------------------------
      // Slow-wait, woken by a peripheral
      // ----------------------------------------
      sel = 2'($urandom_range(3));
      bus(1'b1, `PMC_OFS_MISC, {29'h0, sel, 1'b1});
      cpu.exec(1'b0);
      @(negedge mclk);
      check("wait mask clr", 32'(iMaskClr), 32'h1);
      at_neg(1);
      gates("wait gates", 4'h7);
      period(per);
      check("wait period", 32'(per), expPeriod(1'b1, sel));
      irqPeriph <= 1'b1;
      wait_go(8);
      irqPeriph <= 1'b0;
      at_neg(1);
      check("svc mask set", 32'(iMaskSet), 32'h1);
      at_neg(11);
      gates("woke gates", 4'hf);
      bus(1'b1, `PMC_OFS_MISC, 32'h0);
      $display("test wait finished");
      // ----------------------------------------
      // Plain halt ignores timebase and peripherals
      // ----------------------------------------
      watchdogActive <= 1'b1;
      cpu.exec(1'b1);
      at_neg(2);
      gates("halt gates", 4'h0);
      check("halt tick", 32'(masterTick), 32'h0);
      @(posedge mclk);
      timebaseIrq <= 1'b1;
      clockSecurityIrq <= 1'b1;
      irqPeriph <= 1'b1;
      at_neg(8);
      check("halt held", 32'(oscEnable), 32'h0);
      @(posedge mclk);
      timebaseIrq <= 1'b0;
      clockSecurityIrq <= 1'b0;
      irqPeriph <= 1'b0;
      extIrqPin <= 4'($urandom_range(15, 1));
      at_neg(5);
      check("hold", 32'({cpuHold, oscEnable}), 32'h3);
      @(posedge mclk);
      extIrqPin <= 4'h0;
      wait_go(2 * SC + 40);
      check("no wdg", 32'(wdgSeen), 32'h0);
      $display("test halt finished");
      // ----------------------------------------
      // Active-halt with watchdog running
      // ----------------------------------------
      bus(1'b1, `PMC_OFS_CLKCTRL, 32'h1);
      bus(1'b1, `PMC_OFS_OPTION, 32'h1);
      cpu.exec(1'b1);
      at_neg(3);
      gates("ahalt gates", 4'h3);
      @(posedge mclk);
      timebaseIrq <= 1'b1;
      wait_go(2 * SC + 40);
      timebaseIrq <= 1'b0;
      check("ahalt wdg", 32'(wdgSeen), 32'h0);
      at_neg(10);
      @(posedge mclk);
      irqWakeCapable <= 1'b1;
      cpu.exec(1'b1);
      at_neg(3);
      check("pending wake", 32'(cpuHold), 32'h1);
      @(posedge mclk);
      irqWakeCapable <= 1'b0;
      wait_go(2 * SC + 40);
      $display("test active halt finished");
      // ----------------------------------------
      // Halt refused into a watchdog reset
      // ----------------------------------------
      at_neg(10);
      bus(1'b1, `PMC_OFS_CLKCTRL, 32'h0);
      cpu.exec(1'b1);
      at_neg(3);
      check("wdg reset", 32'({wdgSeen, oscEnable}), 32'h3);
      $display("test watchdog finished");
      print_verdict();
   end
endmodule : pmc_power_mode_controller_bench
